// [shared/burst_sram_defs.vh]
// constants for the pipelined burst sram access block
// assumes a single rising-edge clock domain
`ifndef BURST_SRAM_DEFS_VH
`define BURST_SRAM_DEFS_VH
`define ADDR_W_DEF       18
`define DATA_W_DEF       32
`define LANES_DEF        4
`define BURST_LSB        0
`define BURST_MSB        1
`define BURST_ZERO       2'h0
`define BURST_ONE        2'h1
`define SLEEP_CYCLES     2'h2
`define SLEEP_CNT_ZERO   2'h0
`define ST_IDLE          2'h0
`define ST_ACTIVE        2'h1
`define ST_SLEEP         2'h2
`define ST_WAKE          2'h3
`endif

// [rtl/burst_sram_access.v]
// synchronous access logic and array of a pipelined burst sram
// assumes a bus master on a common data bus and a static burst-order strap
`include "burst_sram_defs.vh"
`default_nettype none

module burst_sram_access #(
  parameter ADDR_W = `ADDR_W_DEF,
  parameter DATA_W = `DATA_W_DEF,
  parameter LANES  = `LANES_DEF
) (
  input  wire              mclk_in,                          // 100 MHz clock
  input  wire              reset_in,                         // sync reset, active high
  input  wire [ADDR_W-1:0] addr_in,                          // address
  input  wire              processor_addr_strobe_n_in,       // processor strobe, low active
  input  wire              controller_addr_strobe_n_in,      // controller strobe, low active
  input  wire              burst_advance_n_in,               // burst advance, low active
  input  wire              global_write_n_in,                // global write, low active
  input  wire              byte_write_enable_n_in,           // byte write enable, low active
  input  wire [LANES-1:0]  byte_lane_select_n_in,            // per-byte selects, low active
  input  wire              chip_sel_primary_n_in,            // primary select, low active
  input  wire              chip_sel_depth_high_in,           // depth select, high active
  input  wire              chip_sel_depth_low_n_in,          // depth select, low active
  input  wire              output_enable_n_in,               // output enable, low active
  input  wire              sleep_request_in,                 // sleep request, high active
  input  wire              burst_order_strap_in,             // 1 interleaved, 0 linear
  input  wire [DATA_W-1:0] data_in,                          // data bus level in
  output wire [DATA_W-1:0] data_out,                         // data bus drive value
  output wire              data_oe_out,                      // data bus drive enable
  output wire              sleep_active_out                  // low-power state indicator
);

  localparam BYTE_W = DATA_W / LANES;
  localparam DEPTH  = 1 << ADDR_W;

  // ---------------------------------------------------------------
  // burst address function
  // ---------------------------------------------------------------
  function [1:0] burst_addr;
    input [1:0] start;
    input [1:0] count;
    input       interleaved;
    begin
      if (interleaved)
        burst_addr = start ^ count;
      else
        burst_addr = start + count;
    end
  endfunction

  // ---------------------------------------------------------------
  // input registers
  // ---------------------------------------------------------------
  reg [ADDR_W-1:0] addr_ff;
  reg              processor_addr_strobe_n_ff;
  reg              controller_addr_strobe_n_ff;
  reg              adv_n_ff;
  reg              gw_n_ff;
  reg              bwe_n_ff;
  reg [LANES-1:0]  bw_n_ff;
  reg              ce1_n_ff;
  reg              ce2_ff;
  reg              ce3_n_ff;
  reg [DATA_W-1:0] din_ff;
  reg              zz_meta_ff;
  reg              zz_sync_ff;
  reg              strap_ff;

  always @(posedge mclk_in)
  begin
    addr_ff    <= addr_in;
    processor_addr_strobe_n_ff  <= processor_addr_strobe_n_in;
    controller_addr_strobe_n_ff  <= controller_addr_strobe_n_in;
    adv_n_ff   <= burst_advance_n_in;
    gw_n_ff    <= global_write_n_in;
    bwe_n_ff   <= byte_write_enable_n_in;
    bw_n_ff    <= byte_lane_select_n_in;
    ce1_n_ff   <= chip_sel_primary_n_in;
    ce2_ff     <= chip_sel_depth_high_in;
    ce3_n_ff   <= chip_sel_depth_low_n_in;
    din_ff     <= data_in;
    zz_meta_ff <= sleep_request_in;
    zz_sync_ff <= zz_meta_ff;
    strap_ff   <= burst_order_strap_in;
  end

  // ---------------------------------------------------------------
  // cycle decode on registered inputs
  // ---------------------------------------------------------------
  reg  [1:0] state_ff;
  reg  [1:0] sleep_cnt_ff;
  reg        selected_ff;
  wire       awake     = (state_ff == `ST_IDLE) || (state_ff == `ST_ACTIVE);
  wire       all_sel   = !ce1_n_ff && ce2_ff && !ce3_n_ff;
  wire       processor_addr_strobe_go   = !processor_addr_strobe_n_ff && !ce1_n_ff;
  wire       strobe    = processor_addr_strobe_go || !controller_addr_strobe_n_ff;
  wire       start     = awake && strobe && all_sel;
  wire       deselect  = awake && strobe && !all_sel;
  wire       wr_req    = !gw_n_ff || (!bwe_n_ff && !(&bw_n_ff));
  wire       processor_addr_strobe_first = start && processor_addr_strobe_go;
  wire       controller_addr_strobe_write = start && !processor_addr_strobe_go && wr_req;
  wire       rd_start  = start && !wr_req && !processor_addr_strobe_go;
  wire       continue_cyc = awake && !strobe && selected_ff;
  wire       cont_write = continue_cyc && wr_req;
  wire       do_write  = controller_addr_strobe_write || cont_write;
  wire       advance   = continue_cyc && !adv_n_ff;

  reg              first_ff;
  reg [ADDR_W-1:0] base_ff;
  reg [1:0]        cnt_ff;

  // ---------------------------------------------------------------
  // burst counter and select tracking
  // ---------------------------------------------------------------
  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      selected_ff <= 1'b0;
      first_ff    <= 1'b0;
      cnt_ff      <= `BURST_ZERO;
      base_ff     <= {ADDR_W{1'b0}};
    end
    else if (!awake)
    begin
      selected_ff <= 1'b0;
      first_ff    <= 1'b0;
    end
    else if (start)
    begin
      base_ff     <= addr_ff;
      cnt_ff      <= `BURST_ZERO;
      first_ff    <= !selected_ff;
      selected_ff <= 1'b1;
    end
    else if (deselect)
    begin
      selected_ff <= 1'b0;
      first_ff    <= 1'b0;
    end
    else
    begin
      first_ff <= 1'b0;
      if (advance)
        cnt_ff <= cnt_ff + `BURST_ONE;
    end
  end

  // ---------------------------------------------------------------
  // array address and write path
  // ---------------------------------------------------------------
  // upper address bits stay fixed for the whole burst
  localparam HI_LSB = `BURST_MSB + 1;
  wire [1:0]        low_bits = burst_addr(base_ff[`BURST_MSB:`BURST_LSB], cnt_ff, strap_ff);
  wire [ADDR_W-1:0] cur_addr = {base_ff[ADDR_W-1:HI_LSB], low_bits};
  wire [ADDR_W-1:0] acc_addr = start ? addr_ff : cur_addr;
  // continue-write steps address before storing, like a read would
  wire [1:0]        adv_bits = burst_addr(base_ff[`BURST_MSB:`BURST_LSB], cnt_ff + `BURST_ONE, strap_ff);
  wire [ADDR_W-1:0] wr_addr  = controller_addr_strobe_write ? addr_ff :
                               (advance ? {base_ff[ADDR_W-1:HI_LSB], adv_bits} : cur_addr);
  wire [ADDR_W-1:0] rd_addr  = advance ? {base_ff[ADDR_W-1:HI_LSB], adv_bits} : acc_addr;

  reg [DATA_W-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge mclk_in)
  begin
    if (do_write && !processor_addr_strobe_first)
    begin
      for (i = 0; i < LANES; i = i + 1)
      begin
        if (!gw_n_ff || (!bwe_n_ff && !bw_n_ff[i]))
          mem[wr_addr][i*BYTE_W +: BYTE_W] <= din_ff[i*BYTE_W +: BYTE_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // output register and drive control
  // ---------------------------------------------------------------
  reg [DATA_W-1:0] dout_ff;
  reg              drive_ff;
  wire             rd_cyc = rd_start || processor_addr_strobe_first || (continue_cyc && !wr_req);

  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      dout_ff  <= {DATA_W{1'b0}};
      drive_ff <= 1'b0;
    end
    else
    begin
      if (rd_cyc)
        dout_ff <= mem[rd_addr];
      drive_ff <= rd_cyc && !do_write && !(start && !selected_ff);
    end
  end

  assign data_out    = dout_ff;
  // write or deselect in the decode cycle drops the bus at once
  assign data_oe_out = drive_ff && !first_ff && !output_enable_n_in && awake
                       && !do_write && !deselect;

  // ---------------------------------------------------------------
  // sleep sequencing
  // ---------------------------------------------------------------
  reg [1:0] nxt_state;
  reg [1:0] nxt_sleep_cnt;

  // two synchroniser edges come before the two counted cycles
  always @*
  begin
    nxt_state     = state_ff;
    nxt_sleep_cnt = sleep_cnt_ff;
    case (state_ff)
      `ST_IDLE, `ST_ACTIVE:
      begin
        if (zz_sync_ff)
        begin
          if (sleep_cnt_ff == `SLEEP_CYCLES - `BURST_ONE)
          begin
            nxt_state     = `ST_SLEEP;
            nxt_sleep_cnt = `SLEEP_CNT_ZERO;
          end
          else
            nxt_sleep_cnt = sleep_cnt_ff + `BURST_ONE;
        end
        else
          nxt_sleep_cnt = `SLEEP_CNT_ZERO;
      end
      `ST_SLEEP:
      begin
        if (!zz_sync_ff)
        begin
          nxt_state     = `ST_WAKE;
          nxt_sleep_cnt = `SLEEP_CNT_ZERO;
        end
      end
      `ST_WAKE:
      begin
        if (zz_sync_ff)
          nxt_state = `ST_SLEEP;
        else if (sleep_cnt_ff == `SLEEP_CYCLES - `BURST_ONE - `BURST_ONE)
        begin
          nxt_state     = `ST_IDLE;
          nxt_sleep_cnt = `SLEEP_CNT_ZERO;
        end
        else
          nxt_sleep_cnt = sleep_cnt_ff + `BURST_ONE;
      end
      default:
      begin
        nxt_state     = `ST_IDLE;
        nxt_sleep_cnt = `SLEEP_CNT_ZERO;
      end
    endcase
  end

  always @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      state_ff     <= `ST_IDLE;
      sleep_cnt_ff <= `SLEEP_CNT_ZERO;
    end
    else
    begin
      state_ff     <= nxt_state;
      sleep_cnt_ff <= nxt_sleep_cnt;
    end
  end

  assign sleep_active_out = !awake;

endmodule // burst_sram_access
`default_nettype wire

// [verif/burst_sram_access_checker.sv]
// assertions on the ports of the burst sram access block
// assumes one clock domain with a synchronous active-high reset
`default_nettype none
module burst_sram_access_checker #(
  parameter DATA_W = 32
) (
  input wire logic              mclk_in,
  input wire logic              reset_in,
  input wire logic              processor_addr_strobe_n_in,
  input wire logic              controller_addr_strobe_n_in,
  input wire logic              chip_sel_primary_n_in,
  input wire logic              chip_sel_depth_high_in,
  input wire logic              chip_sel_depth_low_n_in,
  input wire logic              output_enable_n_in,
  input wire logic              sleep_request_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_out,
  input wire logic              sleep_active_out
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  wire strobe = !processor_addr_strobe_n_in || !controller_addr_strobe_n_in;
  wire sel = !chip_sel_primary_n_in && chip_sel_depth_high_in && !chip_sel_depth_low_n_in;
  wire desel = (chip_sel_primary_n_in && !controller_addr_strobe_n_in) || (!chip_sel_primary_n_in && !sel && strobe);
  sequence reselect;
    desel ##1 (strobe && sel);
  endsequence
  oe_gate_a: assert property (data_oe_out |-> !output_enable_n_in)
    else $error("bus driven with output enable off");
  sleep_quiet_a: assert property (sleep_active_out |-> !data_oe_out)
    else $error("bus driven while asleep");
  sleep_enter_a: assert property (sleep_request_in [*6] |-> sleep_active_out)
    else $error("sleep not entered in time");
  sleep_exit_a: assert property ((!sleep_request_in) [*6] |-> !sleep_active_out)
    else $error("sleep not left in time");
  sleep_delay_a: assert property ($rose(sleep_request_in) |-> !sleep_active_out ##1 !sleep_active_out)
    else $error("sleep entered too early");
  desel_off_a: assert property (desel |-> ##1 !data_oe_out)
    else $error("bus driven after deselect");
  first_off_a: assert property (reselect |-> ##2 !data_oe_out)
    else $error("first access after deselect drove the bus");
  sleep_hold_a: assert property (sleep_active_out [*4] |-> $stable(data_out))
    else $error("read data changed while asleep");
endmodule  // burst_sram_access_checker
bind burst_sram_access burst_sram_access_checker #(.DATA_W(DATA_W)) chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .processor_addr_strobe_n_in(processor_addr_strobe_n_in), .controller_addr_strobe_n_in(controller_addr_strobe_n_in),
  .chip_sel_primary_n_in(chip_sel_primary_n_in), .chip_sel_depth_high_in(chip_sel_depth_high_in),
  .chip_sel_depth_low_n_in(chip_sel_depth_low_n_in), .output_enable_n_in(output_enable_n_in),
  .sleep_request_in(sleep_request_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .sleep_active_out(sleep_active_out));
`default_nettype wire

// [verif/sram_bus_master_model.sv]
// bus master model: resolves the shared data bus and output enable
// assumes the sram splits its data pin into value and enable
`default_nettype none
module sram_bus_master_model (
  input  wire logic        drive_in,  // write data on bus
  input  wire logic        read_in,   // wants read data
  input  wire logic [31:0] wdata_in,  // write data
  input  wire logic [31:0] dq_in,     // sram value
  input  wire logic        dq_oe_in,  // sram enable
  output logic      [31:0] bus_out,   // bus level
  output logic             oe_n_out   // output enable
);
  timeunit 1ns / 1ps;
  assign oe_n_out = drive_in | ~read_in;
  assign bus_out  = dq_oe_in ? dq_in : (drive_in ? wdata_in : ~wdata_in);
endmodule  // sram_bus_master_model
`default_nettype wire

// [verif/test_pipelined_burst_sram_access.sv]
// self-checking bench for the burst sram access block
// assumes design defaults of 18 address and 32 data bits
`default_nettype none
module test_pipelined_burst_sram_access;
  timeunit 1ns / 1ps;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
  logic        clk = 1'h0, rst = 1'h1, ps = 1'h1, cs = 1'h1, burst_advance = 1'h1, gw = 1'h1, byte_write_enable = 1'h1;
  logic        c1 = 1'h0, c2 = 1'h1, c3 = 1'h0, zz = 1'h0, strap = 1'h1, drv = 1'h0, rd = 1'h0;
  logic [3:0]  bl = 4'hf;
  logic [17:0] a = 18'h0_0000, base = 18'h0_0100;
  logic [31:0] wd = 32'h0000_0000, old;
  wire  [31:0] bus, q;
  wire         oe, oe_n, slp;
  int          err_count = 0, compares = 0;
  logic [8:0]  rows [8] = '{9'h11b, 9'h14e, 9'h1b1, 9'h1e4, 9'h01b, 9'h06c, 9'h0b1, 9'h0c6};
  burst_sram_access dut (.mclk_in(clk), .reset_in(rst), .addr_in(a), .processor_addr_strobe_n_in(ps),
    .controller_addr_strobe_n_in(cs), .burst_advance_n_in(burst_advance), .global_write_n_in(gw),
    .byte_write_enable_n_in(byte_write_enable), .byte_lane_select_n_in(bl), .chip_sel_primary_n_in(c1),
    .chip_sel_depth_high_in(c2), .chip_sel_depth_low_n_in(c3), .output_enable_n_in(oe_n),
    .sleep_request_in(zz), .burst_order_strap_in(strap), .data_in(bus), .data_out(q),
    .data_oe_out(oe), .sleep_active_out(slp));
  sram_bus_master_model partner (.drive_in(drv), .read_in(rd), .wdata_in(wd), .dq_in(q),
    .dq_oe_in(oe), .bus_out(bus), .oe_n_out(oe_n));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] pat(input logic [17:0] x);
    return {x[7:0], ~x[7:0], x[15:8], 8'h5a};
  endfunction
  task automatic tick;
    @(posedge clk);
  endtask
  task automatic quiet(input logic prim);
    tick;
    {ps, cs, burst_advance, gw, byte_write_enable, drv, c1} <= {6'h3e, prim};
  endtask
  task automatic desel;
    tick;
    {ps, cs, burst_advance, gw, byte_write_enable, drv, c1} <= 7'h5d;
  endtask
  task automatic wr(input logic [17:0] ad, input logic [31:0] d, input logic [3:0] ln, input logic g);
    tick;
    {ps, cs, c1, byte_write_enable, drv, a, wd, bl, gw} <= {5'h11, ad, d, ln, g};
  endtask
  task automatic rdchk(input logic [17:0] ad, input logic [31:0] e);
    repeat (2) quiet(1'h0);
    tick;
    {cs, a, rd} <= {1'h0, ad, 1'h1};
    tick;
    cs <= 1'h1;
    repeat (2) tick;
    #1 `CHK(q, e)
  endtask
  task automatic report_and_stop;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_slp(input logic v);
    for (int n = 0; n < 20 && slp !== v; n++)
      tick;
    if (slp !== v)
    begin
      err_count++;
      report_and_stop();
    end
  endtask
  initial
  begin
    repeat (3) tick;
    rst <= 1'h0;
    for (int i = 0; i < 4; i++)
      wr(base + 18'(i), pat(base + 18'(i)), 4'h0, i[0]);
    foreach (rows[r])
    begin
      desel;
      strap <= rows[r][8];
      tick;
      {c1, cs, a, rd} <= {2'h0, base | 18'(rows[r][7:6]), 1'h1};
      for (int k = 1; k < 7; k++)
      begin
        tick;
        {cs, burst_advance} <= {1'h1, k > 3};
        #1;
        if (k >= 2) `CHK(q, pat(base | 18'(rows[r][7 - 2 * ((k > 5 ? 5 : k) - 2) -: 2])))
        if (k == 2) `CHK(oe, 1'h0)
        if (k == 3) `CHK(oe, 1'h1)
      end
    end
    $display("burst order test done");
    old = pat(base);
    wr(base, 32'h1122_3344, 4'ha, 1'h1);
    wr(base + 18'h1, 32'h5566_7788, 4'hf, 1'h0);
    rdchk(base, {old[31:24], 8'h22, old[15:8], 8'h44});
    rdchk(base + 18'h1, 32'h5566_7788);
    $display("byte write test done");
    tick;
    {ps, a, byte_write_enable, bl} <= {1'h0, base + 18'h2, 1'h0, 4'h0};
    tick;
    {ps, gw, byte_write_enable, bl, drv, wd} <= {3'h5, 4'hf, 1'h1, 32'h99aa_bbcc};
    rdchk(base + 18'h2, 32'h99aa_bbcc);
    tick;
    {ps, c1, a} <= {2'h1, base + 18'h3};
    repeat (3) tick;
    #1 `CHK(q, 32'h99aa_bbcc)
    `CHK(oe, 1'h1)
    $display("processor strobe test done");
    desel;
    quiet(1'h1);
    zz <= 1'h1;
    wait_slp(1'h1);
    repeat (6) tick;
    #1 `CHK(oe, 1'h0)
    tick;
    zz <= 1'h0;
    wait_slp(1'h0);
    repeat (2) quiet(1'h1);
    rdchk(base + 18'h1, 32'h5566_7788);
    $display("sleep test done");
    tick;
    rst <= 1'h1;
    repeat (2) tick;
    #1 `CHK(q, 32'h0000_0000)
    `CHK(oe, 1'h0)
    tick;
    rst <= 1'h0;
    rdchk(base + 18'h2, 32'h99aa_bbcc);
    $display("reset test done");
    report_and_stop();
  end
endmodule  // test_pipelined_burst_sram_access
`default_nettype wire
